/* File: hw/ebms_params.svh */
`ifndef EBMS_PARAMS_SVH
`define EBMS_PARAMS_SVH
`define EBMS_NUM_CS        4
`define EBMS_FMT_NATIVE    2'h0
`define EBMS_FMT_THREE     2'h1
`define EBMS_FMT_FOUR      2'h2
`define EBMS_CNT_MIN3      4'h1
`define EBMS_CNT_MIN4      4'h2
`define EBMS_CNT_MAX       4'hF
`define EBMS_FMT_RST       2'h0
`define EBMS_MUX_RST       1'b0
`define EBMS_CNT_RST       4'h1
`endif

/* File: hw/ebms_pkg.sv */
package ebms_pkg;
  // bus cycle phase
  typedef enum logic [2:0] {
    EBMS_IDLE = 3'b000,
    EBMS_T1   = 3'b001,
    EBMS_T2   = 3'b010,
    EBMS_T3   = 3'b011,
    EBMS_T4   = 3'b100,
    EBMS_STR  = 3'b101
  } ebms_state_e;
  typedef logic [1:0] ebms_fmt_t;
  typedef logic [3:0] ebms_cnt_t;
endpackage : ebms_pkg

/* File: hw/ebms_sequencer.sv */
`timescale 1ns/1ns
`include "ebms_params.svh"
module ebms_sequencer
  import ebms_pkg::*;
(
  input  wire logic        clk_sys_i,        // 10 MHz system clock
  input  wire logic        sys_rst_i,        // sync reset, active high
  input  wire logic [3:0]  cfg_we_i,         // per select config write strobe
  input  wire logic [1:0]  cfg_fmt_i,        // format to write
  input  wire logic        cfg_mux_i,        // multiplexed option to write
  input  wire logic [3:0]  cfg_cnt_i,        // clocks per state to write
  input  wire logic [3:0]  cs_hit_i,         // decoded selects, one hot, live
  input  wire logic        cpu_req_i,        // cpu external access pending
  input  wire logic        cpu_wr_i,         // 1 write, 0 read
  input  wire logic        cpu_io_i,         // 1 io space, 0 memory
  input  wire logic [23:0] cpu_addr_i,       // cpu address
  input  wire logic [7:0]  cpu_wdata_i,      // cpu write data
  input  wire logic        cpu_cs_n_i,       // native select from cpu
  input  wire logic        cpu_rd_n_i,       // native read strobe
  input  wire logic        cpu_wr_n_i,       // native write strobe
  input  wire logic        cpu_memory_request_n_n_i,     // native memory request
  input  wire logic        cpu_io_request_n_n_i,     // native io request
  input  wire logic        wait_n_i,         // peripheral wait/ready, low stalls
  input  wire logic        ext_master_request_i, // external bus request
  input  wire logic        reg_access_i,     // cpu access to internal registers
  input  wire logic [7:0]  data_pin_i,       // data bus pins in
  output logic             cpu_done_o,       // one cycle: access complete
  output logic [7:0]       cpu_rdata_o,      // captured read data
  output logic             reg_access_ok_o,  // internal register access allowed
  output logic             bus_grant_acknowledge_n_o, // low while bus released
  output logic [23:0]      addr_o,           // address pins
  output logic             addr_oe_o,        // address pins driven
  output logic [7:0]       data_o,           // data pins out
  output logic             data_oe_o,        // data pins driven
  output logic [3:0]       cs_n_o,           // chip select pins
  output logic             rd_n_o,           // read strobe pin
  output logic             wr_n_o,           // write strobe pin
  output logic             memory_request_n_o, // memory request pin
  output logic             io_request_n_o,   // io request pin
  output logic             ale_o             // address latch strobe
);

  // whole state of the block
  typedef struct packed {
    ebms_fmt_t [3:0] fmt;      // per select format
    logic [3:0]      mux;      // per select multiplexed
    ebms_cnt_t [3:0] cnt;      // per select clocks per state
    ebms_state_e     st;       // cycle phase
    ebms_cnt_t       tick;     // cycles left in phase
    ebms_cnt_t       len;      // latched phase length
    logic            four;     // cycle is four-state
    logic            mx;       // cycle multiplexed
    logic            wr;       // cycle is write
    logic            io;       // cycle io space
    logic [3:0]      sel;      // latched select
    logic [23:0]     addr;     // latched address
    logic [7:0]      wdata;    // latched write data
    logic [7:0]      rdata;    // captured read data
    logic            done;     // completion pulse
    logic            stall;    // wait sampled low
    logic            grant;    // bus released
  } ebms_s;

  ebms_s r;
  ebms_s next_r;
  logic  last;                 // final cycle of current phase
  logic  hold_t3;              // wait holds the cycle in stretch
  ebms_fmt_t fsel;             // format of live select
  ebms_cnt_t craw;             // raw count of live select
  logic  msel;                 // mux option of live select

  // pick config of the lowest hit select
  always_comb begin
    fsel = `EBMS_FMT_NATIVE;
    craw = `EBMS_CNT_RST;
    msel = 1'b0;
    for (int i = `EBMS_NUM_CS - 1; i >= 0; i--) begin
      if (cs_hit_i[i]) begin
        fsel = r.fmt[i];
        craw = r.cnt[i];
        msel = r.mux[i];
      end
    end
  end

  assign last = (r.tick == 4'h1);
  // wait is a registered sample, so the peripheral must act a clock early
  assign hold_t3 = r.stall;

  // next state
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.stall = ~wait_n_i;
    next_r.grant = ext_master_request_i && (r.st == EBMS_IDLE);
    if (r.grant && ext_master_request_i) begin
      next_r.grant = 1'b1;
    end
    for (int i = 0; i < `EBMS_NUM_CS; i++) begin
      if (cfg_we_i[i]) begin
        next_r.fmt[i] = (cfg_fmt_i > `EBMS_FMT_FOUR) ? `EBMS_FMT_FOUR : cfg_fmt_i;
        next_r.mux[i] = cfg_mux_i;
        next_r.cnt[i] = (cfg_cnt_i == 4'h0) ? `EBMS_CNT_MIN3 : cfg_cnt_i;
      end
    end
    case (r.st)
      EBMS_IDLE: begin
        if (cpu_req_i && !r.grant && !ext_master_request_i && fsel != `EBMS_FMT_NATIVE) begin
          next_r.st = EBMS_T1;
          next_r.four = (fsel == `EBMS_FMT_FOUR);
          next_r.mx = msel && (fsel == `EBMS_FMT_FOUR);
          if (fsel == `EBMS_FMT_FOUR && craw < `EBMS_CNT_MIN4) begin
            next_r.len = `EBMS_CNT_MIN4;
          end else begin
            next_r.len = craw;
          end
          next_r.tick = (fsel == `EBMS_FMT_FOUR && craw < `EBMS_CNT_MIN4) ?
                        `EBMS_CNT_MIN4 : craw;
          next_r.wr = cpu_wr_i;
          next_r.io = cpu_io_i;
          next_r.sel = cs_hit_i;
          next_r.addr = cpu_addr_i;
          next_r.wdata = cpu_wdata_i;
        end
      end
      EBMS_T1: begin
        next_r.tick = r.tick - 4'h1;
        if (last) begin
          next_r.st = EBMS_T2;
          next_r.tick = r.len;
        end
      end
      EBMS_T2: begin
        next_r.tick = r.tick - 4'h1;
        if (last) begin
          next_r.st = EBMS_T3;
          next_r.tick = r.len;
        end
      end
      EBMS_T3: begin
        next_r.tick = r.tick - 4'h1;
        if (!r.four && !wait_n_i) begin
          next_r.tick = r.tick;
        end else if (last) begin
          if (r.four) begin
            next_r.st = EBMS_T4;
            next_r.tick = r.len;
            if (!r.wr) begin
              next_r.rdata = data_pin_i;
            end
          end else begin
            next_r.st = EBMS_IDLE;
            next_r.done = 1'b1;
            if (!r.wr) begin
              next_r.rdata = data_pin_i;
            end
          end
        end
        if (r.four && hold_t3 && r.tick == r.len) begin
          next_r.st = EBMS_STR;
          next_r.tick = r.tick;
        end
      end
      EBMS_STR: begin
        // resume on the first edge after ready returns
        if (wait_n_i) begin
          next_r.st = EBMS_T3;
        end
      end
      EBMS_T4: begin
        next_r.tick = r.tick - 4'h1;
        if (last) begin
          next_r.st = EBMS_IDLE;
          next_r.done = 1'b1;
        end
      end
      default: begin
        next_r.st = EBMS_IDLE;
      end
    endcase
  end

  // register the state
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      r <= '0;
      for (int i = 0; i < `EBMS_NUM_CS; i++) begin
        r.fmt[i] <= `EBMS_FMT_RST;
        r.mux[i] <= `EBMS_MUX_RST;
        r.cnt[i] <= `EBMS_CNT_RST;
      end
    end else begin
      r <= next_r;
    end
  end

  // pin drive
  always_comb begin
    logic act;
    logic strb;
    logic t1;
    act  = (r.st != EBMS_IDLE);
    t1   = (r.st == EBMS_T1);
    strb = (r.st == EBMS_T2) || (r.st == EBMS_T3) || (r.st == EBMS_STR) ||
           (r.st == EBMS_T4 && !r.wr);
    cpu_done_o = r.done;
    cpu_rdata_o = r.rdata;
    bus_grant_acknowledge_n_o = ~r.grant;
    reg_access_ok_o = reg_access_i && !r.grant;
    addr_o = cpu_addr_i;
    addr_oe_o = !r.grant;
    data_o = cpu_wdata_i;
    data_oe_o = cpu_wr_i && !r.grant;
    cs_n_o = ~cs_hit_i;
    rd_n_o = cpu_rd_n_i;
    wr_n_o = cpu_wr_n_i;
    memory_request_n_o = cpu_memory_request_n_n_i;
    io_request_n_o = cpu_io_request_n_n_i;
    ale_o = 1'b0;
    if (r.grant) begin
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      memory_request_n_o = 1'b1;
      io_request_n_o = 1'b1;
    end else if (act) begin
      addr_o = r.addr;
      cs_n_o = ~r.sel;
      // address latch pulses in the first half of T1, four-state format only
      ale_o = r.four && t1 && (r.tick > (r.len >> 1));
      rd_n_o = !(strb && !r.wr && r.st != EBMS_T4);
      wr_n_o = !(strb && r.wr && r.st != EBMS_T4);
      memory_request_n_o = !(strb && !r.io && r.st != EBMS_T4);
      io_request_n_o = !(strb && r.io && r.st != EBMS_T4);
      data_o = r.wdata;
      data_oe_o = r.wr && (!r.mx || !t1);
      if (r.mx && t1) begin
        data_o = r.addr[7:0];
        data_oe_o = 1'b1;
      end
    end else if (fsel != `EBMS_FMT_NATIVE && cpu_req_i) begin
      // hold strobes off until the shaped cycle starts
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      memory_request_n_o = 1'b1;
      io_request_n_o = 1'b1;
      cs_n_o = 4'hF;
    end
  end

  // three-state cycle never reaches T4
  three_no_t4_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.st == EBMS_T3 && !r.four) |=> r.st != EBMS_T4) else $error("three-state hit T4");
  four_min_len_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.st == EBMS_T1 && r.four) |-> r.len >= 4'h2) else $error("four-state length short");
  grant_ack_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    r.grant |-> !bus_grant_acknowledge_n_o && !reg_access_ok_o) else $error("grant leak");
  native_pass_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.st == EBMS_IDLE && !r.grant && fsel == `EBMS_FMT_NATIVE) |-> rd_n_o == cpu_rd_n_i)
    else $error("native not passed");
  mux_addr_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.st == EBMS_T1 && r.mx && !r.grant) |-> data_o == r.addr[7:0]) else $error("no mux addr");
  write_end_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.st == EBMS_T4 && !r.grant) |-> wr_n_o) else $error("write strobe in T4");
  resume_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.st == EBMS_STR && wait_n_i) |=> r.st == EBMS_T3) else $error("no resume");
  t2_strobe_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.st == EBMS_T2 && !r.grant) |-> (rd_n_o != wr_n_o)) else $error("T2 strobe");

endmodule : ebms_sequencer

/* File: tb/ebms_periph.sv */
`timescale 1ns/1ns
module ebms_periph (
  input  wire logic       clk_sys_i, // system clock
  input  wire logic       rd_n_i,    // read strobe from block
  input  wire logic       wr_n_i,    // write strobe from block
  input  wire logic [7:0] addr_lo_i, // low address byte
  input  wire logic [4:0] stall_i,   // wait cycles per strobe, 0 none
  output logic            wait_n_o,  // ready back to block
  output logic [7:0]      rdata_o    // read data onto bus
);
  logic [4:0] left;  // stall cycles remaining
  logic       armed; // one stall per strobe
  initial begin
    wait_n_o = 1'b1;
    rdata_o  = 8'h00;
    left     = 5'h00;
    armed    = 1'b1;
  end
  // stall starts just after the strobe falls; it must outlast the strobe state
  // so that wait is still low when the block samples it
  always @(posedge clk_sys_i) begin
    #1;
    if ((!rd_n_i || !wr_n_i) && armed && stall_i != 5'h00) begin
      left  = stall_i;
      armed = 1'b0;
    end
    if (rd_n_i && wr_n_i) armed = 1'b1;
    wait_n_o = (left == 5'h00);
    if (left != 5'h00) left = left - 5'h01;
    // flip when not read so a stale byte never passes for data
    rdata_o = !rd_n_i ? (addr_lo_i ^ 8'hA5) : ~rdata_o;
  end
endmodule : ebms_periph

/* File: tb/test_external_bus_mode_sequencer.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_external_bus_mode_sequencer;
  import ebms_pkg::*;
  logic clk_sys_i = 0, sys_rst_i = 1, cfg_mux_i = 0, cpu_req_i = 0, cpu_wr_i = 0, cpu_io_i = 0;
  logic cpu_cs_n_i = 1, cpu_rd_n_i = 1, cpu_wr_n_i = 1, cpu_memory_request_n_n_i = 1, cpu_io_request_n_n_i = 1;
  logic wait_n_i, ext_master_request_i = 0, reg_access_i = 0;
  logic [3:0]  cfg_we_i = 0, cfg_cnt_i = 1, cs_hit_i = 0;
  logic [4:0]  stall = 0;
  logic [1:0]  cfg_fmt_i = 0;
  logic [23:0] cpu_addr_i = 24'h12345C, addr_o;
  logic [7:0]  cpu_wdata_i = 8'h3C, data_pin_i, cpu_rdata_o, data_o, t1_data, t1_addr, t2_data;
  logic        cpu_done_o, reg_access_ok_o, bus_grant_acknowledge_n_o, addr_oe_o, data_oe_o;
  logic        rd_n_o, wr_n_o, memory_request_n_o, io_request_n_o, ale_o;
  logic [3:0]  cs_n_o;
  int err_count = 0, comparisons = 0, n_cyc, rd_c, wr_c, ale_c, cs_c, rq_c;
  // 10 MHz system clock
  always #50 clk_sys_i = ~clk_sys_i;
  ebms_sequencer dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cfg_we_i(cfg_we_i),
    .cfg_fmt_i(cfg_fmt_i), .cfg_mux_i(cfg_mux_i), .cfg_cnt_i(cfg_cnt_i), .cs_hit_i(cs_hit_i),
    .cpu_req_i(cpu_req_i), .cpu_wr_i(cpu_wr_i), .cpu_io_i(cpu_io_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_cs_n_i(cpu_cs_n_i), .cpu_rd_n_i(cpu_rd_n_i),
    .cpu_wr_n_i(cpu_wr_n_i), .cpu_memory_request_n_n_i(cpu_memory_request_n_n_i), .cpu_io_request_n_n_i(cpu_io_request_n_n_i),
    .wait_n_i(wait_n_i), .ext_master_request_i(ext_master_request_i),
    .reg_access_i(reg_access_i), .data_pin_i(data_pin_i), .cpu_done_o(cpu_done_o),
    .cpu_rdata_o(cpu_rdata_o), .reg_access_ok_o(reg_access_ok_o),
    .bus_grant_acknowledge_n_o(bus_grant_acknowledge_n_o), .addr_o(addr_o),
    .addr_oe_o(addr_oe_o), .data_o(data_o), .data_oe_o(data_oe_o), .cs_n_o(cs_n_o),
    .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .memory_request_n_o(memory_request_n_o),
    .io_request_n_o(io_request_n_o), .ale_o(ale_o));
  ebms_periph periph (.clk_sys_i(clk_sys_i), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .addr_lo_i(addr_o[7:0]), .stall_i(stall), .wait_n_o(wait_n_i), .rdata_o(data_pin_i));
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  // one select's config written for a single edge
  task automatic cfg(input int cs, input logic [1:0] f, input logic m, input logic [3:0] c);
    cfg_we_i  = 4'h1 << cs;
    cfg_fmt_i = f;
    cfg_mux_i = m;
    cfg_cnt_i = c;
    @(posedge clk_sys_i);
    #1;
    cfg_we_i = 4'h0;
  endtask : cfg
  // one shaped access, tallying pin activity per cycle until done
  task automatic access(input logic [3:0] hit, input logic wr, input logic io, input logic [4:0] st);
    cs_hit_i  = hit;
    cpu_wr_i  = wr;
    cpu_io_i  = io;
    stall     = st;
    cpu_req_i = 1'b1;
    {n_cyc, rd_c, wr_c, ale_c, cs_c, rq_c} = '0;
    while (n_cyc < 200) begin
      @(posedge clk_sys_i);
      #1;
      n_cyc++;
      if (n_cyc == 1) {t1_data, t1_addr} = {data_o, addr_o[7:0]};
      if (!wr_n_o && wr_c == 0) t2_data = data_o;
      rd_c += !rd_n_o;
      wr_c += !wr_n_o;
      ale_c += ale_o;
      cs_c += ((cs_n_o & hit) == 4'h0);
      rq_c += io ? !io_request_n_o : !memory_request_n_o;
      if (cpu_done_o === 1'b1) break;
    end
    cpu_req_i = 1'b0;
    if (n_cyc >= 200) begin
      err_count++;
      final_report();
    end
    @(posedge clk_sys_i);
    #1;
  endtask : access
  // plain then stretched access, judged on counts derived from n clocks per state
  task automatic run_chk(input logic [3:0] hit, input int k, input int n, input logic wr, input logic io);
    int base;
    int sb;
    access(hit, wr, io, 5'h00);
    `CHK("cycles", k * n + 1, n_cyc)
    `CHK("select", k * n, cs_c)
    `CHK("strobe", 2 * n, wr ? wr_c : rd_c)
    `CHK("request", 2 * n, rq_c)
    `CHK("latch", (k == 4) ? n / 2 : 0, ale_c)
    if (!wr) `CHK("rdata", cpu_addr_i[7:0] ^ 8'hA5, cpu_rdata_o)
    base = n_cyc;
    sb = wr ? wr_c : rd_c;
    // wait held low two cycles past the end of the strobe state
    access(hit, wr, io, 5'(n + 2));
    `CHK("stretched", 1'b1, n_cyc > base)
    `CHK("stretch strobe", n_cyc - base, (wr ? wr_c : rd_c) - sb)
  endtask : run_chk
  // three-state format on select 0
  task automatic t_three(input logic [3:0] c, input logic wr, input logic io);
    cfg(0, 2'h1, 1'b0, c);
    run_chk(4'h1, 3, (c == 4'h0) ? 1 : int'(c), wr, io);
    $display("three-state test done");
  endtask : t_three
  // four-state format on select 1, separate or multiplexed
  task automatic t_four(input logic [1:0] f, input logic m, input logic [3:0] c, input logic wr);
    cfg(1, f, m, c);
    run_chk(4'h2, 4, (c < 4'h2) ? 2 : int'(c), wr, 1'b0);
    if (m) `CHK("mux addr", cpu_addr_i[7:0], t1_data)
    if (m) `CHK("mux addr bus", cpu_addr_i[7:0], t1_addr)
    if (!m && wr) `CHK("sep wdata", cpu_wdata_i, t1_data)
    if (m && wr) `CHK("mux wdata", cpu_wdata_i, t2_data)
    $display("four-state test done");
  endtask : t_four
  // after reset select 3 passes native strobes straight through
  task automatic t_native();
    cs_hit_i = 4'h8;
    for (int i = 0; i < 16; i++) begin
      {cpu_rd_n_i, cpu_wr_n_i, cpu_memory_request_n_n_i, cpu_io_request_n_n_i} = i[3:0];
      #10;
      `CHK("native", i[3:0], {rd_n_o, wr_n_o, memory_request_n_o, io_request_n_o})
      `CHK("native addr", cpu_addr_i, addr_o)
    end
    {cpu_rd_n_i, cpu_wr_n_i, cpu_memory_request_n_n_i, cpu_io_request_n_n_i} = 4'hF;
    $display("native test done");
  endtask : t_native
  // bus handed to an outside master while decode carries on
  task automatic t_grant();
    int i;
    ext_master_request_i = 1'b1;
    reg_access_i = 1'b1;
    cs_hit_i = 4'h4;
    for (i = 0; i < 5 && bus_grant_acknowledge_n_o !== 1'b0; i++) @(posedge clk_sys_i);
    #1;
    `CHK("grant ack", 1'b0, bus_grant_acknowledge_n_o)
    `CHK("grant select", 4'hB, cs_n_o)
    `CHK("grant regs", 1'b0, reg_access_ok_o)
    ext_master_request_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    `CHK("regs back", 1'b1, reg_access_ok_o)
    $display("grant test done");
  endtask : t_grant
  initial begin
    repeat (5) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    t_native();
    t_three(4'h0, 1'b0, 1'b0);
    t_three(4'hF, 1'b1, 1'b1);
    t_four(2'h2, 1'b0, 4'h2, 1'b0);
    t_four(2'h2, 1'b0, 4'h4, 1'b1);
    t_four(2'h2, 1'b1, 4'h2, 1'b0);
    t_four(2'h3, 1'b1, 4'h1, 1'b1);
    t_three(4'h2, 1'b0, 1'b0);
    t_grant();
    final_report();
  end
endmodule : test_external_bus_mode_sequencer
